/* File: inc/gpm_pkg.sv */
// constants, carriers and function ids for the pin function mux
// Summary of operation
// - four read-only words show the sampled level of pins 0..52, sixteen per word, five in the last
// - one bank bit, reset 1; 1 picks auxiliary meanings, 0 picks debug meanings
// - each clock-out port has a 4-bit source field, codes 1 through B
// - two mode bits per pin, eight per word; 00 keeps plain pin control
// - pins 0..7 code 01 carry LCD data bits 1 up to 8
// - code 11 gives backup SIM data on pin 0; pins 1..4 only in bank 1
// - pins 8..14 code 01 carry LCD control; pin 14 code 11 internal interrupt 30
// - pin 15: 01 audio clock, 10 debug clock by bank, 11 DSP task 2 debug only
// - pins 16..19: audio, debug controls or debug data, DSP task ids by bank
// - pin 20 resets to the boot strap code 10; code 01 is radio bus bit 6
// - pins 21..23: radio bits 7..9, readback/column/select, clock-out ports 0..2; pin 22 code 11 is DSP task 1 in debug bank
// - pins 24,25: buzzer and pwm; debug data and emulation pins in debug bank only
// - pins 26..28: test port inputs on 01, external interrupts 4..6 on 10
// - pin 30 address bits 0 and 25; pin 31 regulator enable, power key, task 0 in debug bank
// - pins 32..39 reset to 01: keypad columns and rows; debug data on 10 in debug bank only
// - six independent clock-out ports, each driven by its own source field
package gpm_pkg;
  localparam int PIN_COUNT    = 53;
  localparam int MUX_PINS     = 40;
  localparam int IN_WORDS     = 4;
  localparam int MODE_REGS    = 5;
  localparam int CLKO_PORTS   = 6;
  localparam int CLKO_SRC_NUM = 12;
  localparam int ADDR_W       = 12;
  localparam int FN_W         = 7;
  localparam int FN_COUNT     = 85;

  localparam logic [11:0] OFF_PIN_INPUT [IN_WORDS] = '{12'h100, 12'h110, 12'h120, 12'h130};
  localparam logic [11:0] OFF_FUNC_SEL [MODE_REGS] =
    '{12'h150, 12'h160, 12'h170, 12'h180, 12'h190};
  localparam logic [15:0] RST_FUNC_SEL [MODE_REGS] =
    '{16'h5555, 16'h1555, 16'h0200, 16'h5150, 16'h5555};
  localparam logic [11:0] OFF_BANK = 12'h1C0;
  localparam logic        RST_BANK = 1'h1;
  localparam logic [11:0] OFF_CLKO_SRC [CLKO_PORTS] =
    '{12'h200, 12'h210, 12'h220, 12'h230, 12'h240, 12'h250};
  localparam logic [3:0]  RST_CLKO_SRC = 4'h0;
  localparam logic [3:0]  CLKO_SRC_MAX = 4'hB;

  // low offset nibble picks plain write, bitwise set or bitwise clear
  localparam logic [1:0]  OP_WRITE = 2'h0;
  localparam logic [1:0]  OP_SET   = 2'h1;
  localparam logic [1:0]  OP_CLR   = 2'h2;

  localparam logic [1:0]  MODE_PLAIN = 2'h0;
  localparam logic [1:0]  MODE_A     = 2'h1;
  localparam logic [1:0]  MODE_B     = 2'h2;
  localparam logic [1:0]  MODE_C     = 2'h3;

  // index of each peripheral function in the function vectors
  localparam logic [6:0] FN_NONE       = 7'h00;
  localparam logic [6:0] FN_LCD_DATA   = 7'h01;
  localparam logic [6:0] FN_BSIM       = 7'h09;
  localparam logic [6:0] FN_LCD_CTRL   = 7'h0E;
  localparam logic [6:0] FN_INT30      = 7'h15;
  localparam logic [6:0] FN_DAI_CLK    = 7'h16;
  localparam logic [6:0] FN_EDI_CLK    = 7'h17;
  localparam logic [6:0] FN_SWD_CLK    = 7'h18;
  localparam logic [6:0] FN_SDSP_TID   = 7'h19;
  localparam logic [6:0] FN_DAI        = 7'h1E;
  localparam logic [6:0] FN_SWD_CTL    = 7'h22;
  localparam logic [6:0] FN_EDI_DATA   = 7'h26;
  localparam logic [6:0] FN_EDI_WS     = 7'h27;
  localparam logic [6:0] FN_RPAR       = 7'h28;
  localparam logic [6:0] FN_ADMUX      = 7'h2C;
  localparam logic [6:0] FN_RSER_RB    = 7'h2D;
  localparam logic [6:0] FN_KCOL5      = 7'h2E;
  localparam logic [6:0] FN_RSER_CS1   = 7'h2F;
  localparam logic [6:0] FN_CLKO       = 7'h30;
  localparam logic [6:0] FN_MDSP_TID1  = 7'h33;
  localparam logic [6:0] FN_ALERT      = 7'h34;
  localparam logic [6:0] FN_PWM        = 7'h35;
  localparam logic [6:0] FN_SWD_DATA   = 7'h36;
  localparam logic [6:0] FN_DSP_IN_CIRCUIT_EMULATION       = 7'h40;
  localparam logic [6:0] FN_JTAG       = 7'h42;
  localparam logic [6:0] FN_EINT       = 7'h45;
  localparam logic [6:0] FN_ADDR_LOW   = 7'h48;
  localparam logic [6:0] FN_ADDR_HIGH  = 7'h49;
  localparam logic [6:0] FN_VCXO_EN    = 7'h4A;
  localparam logic [6:0] FN_PKEY       = 7'h4B;
  localparam logic [6:0] FN_MDSP_TID0  = 7'h4C;
  localparam logic [6:0] FN_KPAD       = 7'h4D;

  typedef struct packed {
    logic [MUX_PINS-1:0] level;
    logic [MUX_PINS-1:0] en;
  } gpm_pad_s;

  typedef struct packed {
    logic [FN_COUNT-1:0] level;
    logic [FN_COUNT-1:0] en;
  } gpm_fn_s;
endpackage

/* File: rtl/gpm_pin_mux.sv */
// pin function mux, pin input sampler and clock-out selection behind apb
`timescale 1ns/1ps
module gpm_pin_mux (
  input  wire logic                                mclk,
  input  wire logic                                rst,
  input  wire logic                                clk_en,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [gpm_pkg::ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [gpm_pkg::PIN_COUNT-1:0]       pin_in,
  input  wire gpm_pkg::gpm_pad_s                   gpio_ctl,
  input  wire gpm_pkg::gpm_fn_s                    periph_drv,
  output gpm_pkg::gpm_pad_s                        pad_drv,
  output logic      [gpm_pkg::FN_COUNT-1:0]        periph_in,
  input  wire logic [gpm_pkg::CLKO_SRC_NUM-1:0]    clk_src,
  output logic      [gpm_pkg::CLKO_PORTS-1:0]      clk_out
);

  logic [15:0]                      func_sel      [gpm_pkg::MODE_REGS];
  logic [15:0]                      next_func_sel [gpm_pkg::MODE_REGS];
  logic [3:0]                       clko_sel      [gpm_pkg::CLKO_PORTS];
  logic [3:0]                       next_clko_sel [gpm_pkg::CLKO_PORTS];
  logic                             bank_sel;
  logic                             next_bank_sel;
  logic [gpm_pkg::PIN_COUNT-1:0]    pin_meta;
  logic [gpm_pkg::PIN_COUNT-1:0]    pin_level;
  logic [63:0]                      pin_words;
  logic [31:0]                      next_prdata;
  logic [gpm_pkg::FN_COUNT-1:0]     next_periph_in;
  logic [gpm_pkg::FN_W-1:0]         pin_fn        [gpm_pkg::MUX_PINS];
  logic [gpm_pkg::FN_COUNT-1:0]     fn_level;
  logic [gpm_pkg::FN_COUNT-1:0]     fn_en;
  logic [gpm_pkg::MUX_PINS-1:0]     pad_level;
  logic [gpm_pkg::MUX_PINS-1:0]     pad_en;
  logic [11:0]                      reg_base;
  logic [1:0]                       reg_op;
  logic [15:0]                      wr_mask;
  logic [15:0]                      rd_val;
  logic                             hit;
  logic                             wr_go;

  // bus write, set or clear on one 16-bit word, masked by byte lanes
  function automatic logic [15:0] gpm_upd(input logic [15:0] cur,
                                          input logic [15:0] wd,
                                          input logic [15:0] msk,
                                          input logic [1:0]  op);
    logic [15:0] v;
    v = cur;
    if (op == gpm_pkg::OP_SET) begin
      v = cur | (wd & msk);
    end else if (op == gpm_pkg::OP_CLR) begin
      v = cur & ~(wd & msk);
    end else begin
      v = (cur & ~msk) | (wd & msk);
    end
    return v;
  endfunction

  // function that a pin carries for its mode code and the bank bit
  function automatic logic [6:0] gpm_route(input int p, input logic [1:0] m, input logic b);
    logic [6:0] f;
    f = gpm_pkg::FN_NONE;
    case (m)
      gpm_pkg::MODE_A: begin
        if (p < 8) begin
          f = gpm_pkg::FN_LCD_DATA + 7'(p);
        end else if (p < 15) begin
          f = gpm_pkg::FN_LCD_CTRL + 7'(p - 8);
        end else if (p == 15) begin
          f = gpm_pkg::FN_DAI_CLK;
        end else if (p < 20) begin
          f = gpm_pkg::FN_DAI + 7'(p - 16);
        end else if (p < 24) begin
          f = gpm_pkg::FN_RPAR + 7'(p - 20);
        end else if (p < 26) begin
          f = gpm_pkg::FN_ALERT + 7'(p - 24);
        end else if (p < 29) begin
          f = gpm_pkg::FN_JTAG + 7'(p - 26);
        end else if (p == 30) begin
          f = gpm_pkg::FN_ADDR_LOW;
        end else if (p == 31) begin
          f = gpm_pkg::FN_VCXO_EN;
        end else if (p > 31) begin
          f = gpm_pkg::FN_KPAD + 7'(p - 32);
        end
      end
      gpm_pkg::MODE_B: begin
        if (p == 15) begin
          f = b ? gpm_pkg::FN_EDI_CLK : gpm_pkg::FN_SWD_CLK;
        end else if (p > 15 && p < 20) begin
          if (!b) begin
            f = gpm_pkg::FN_SWD_CTL + 7'(p - 16);
          end else if (p == 16) begin
            f = gpm_pkg::FN_EDI_DATA;
          end else if (p == 19) begin
            f = gpm_pkg::FN_EDI_WS;
          end
        end else if (p == 20) begin
          f = gpm_pkg::FN_ADMUX;
        end else if (p > 20 && p < 24) begin
          f = gpm_pkg::FN_RSER_RB + 7'(p - 21);
        end else if ((p == 24 || p == 25) && !b) begin
          f = gpm_pkg::FN_SWD_DATA + 7'(p - 24);
        end else if (p > 25 && p < 29) begin
          f = gpm_pkg::FN_EINT + 7'(p - 26);
        end else if (p == 30) begin
          f = gpm_pkg::FN_ADDR_HIGH;
        end else if (p == 31) begin
          f = gpm_pkg::FN_PKEY;
        end else if (p > 31 && !b) begin
          f = gpm_pkg::FN_SWD_DATA + 7'(p - 30);
        end
      end
      gpm_pkg::MODE_C: begin
        if (p == 0 || (p < 5 && b)) begin
          f = gpm_pkg::FN_BSIM + 7'(p);
        end else if (p == 14) begin
          f = gpm_pkg::FN_INT30;
        end else if (p > 14 && p < 20 && !b) begin
          f = gpm_pkg::FN_SDSP_TID + 7'(p - 15);
        end else if (p == 22 && !b) begin
          f = gpm_pkg::FN_MDSP_TID1;
        end else if (p > 20 && p < 24) begin
          f = gpm_pkg::FN_CLKO + 7'(p - 21);
        end else if ((p == 24 || p == 25) && !b) begin
          f = gpm_pkg::FN_DSP_IN_CIRCUIT_EMULATION + 7'(p - 24);
        end else if (p == 31 && !b) begin
          f = gpm_pkg::FN_MDSP_TID0;
        end
      end
      default: f = gpm_pkg::FN_NONE;
    endcase
    // pin 29, the withdrawn serial lcd codes and reserved codes fall through here
    return f;
  endfunction

  // apb decode; every word also answers at +4 (set) and +8 (clear)
  always_comb begin
    reg_base = {paddr[11:4], 4'h0};
    reg_op   = paddr[3:2];
    wr_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wr_go    = psel && penable && pwrite && clk_en;
    hit      = 1'b0;
    rd_val   = 16'h0000;
    next_bank_sel = bank_sel;
    for (int i = 0; i < gpm_pkg::MODE_REGS; i++) begin
      next_func_sel[i] = func_sel[i];
    end
    for (int k = 0; k < gpm_pkg::CLKO_PORTS; k++) begin
      next_clko_sel[k] = clko_sel[k];
    end
    if (reg_op == gpm_pkg::OP_WRITE || reg_op == gpm_pkg::OP_SET ||
        reg_op == gpm_pkg::OP_CLR) begin
      for (int i = 0; i < gpm_pkg::IN_WORDS; i++) begin
        if (reg_base == gpm_pkg::OFF_PIN_INPUT[i]) begin
          hit    = 1'b1;
          rd_val = pin_words[16*i +: 16];
        end
      end
      for (int i = 0; i < gpm_pkg::MODE_REGS; i++) begin
        if (reg_base == gpm_pkg::OFF_FUNC_SEL[i]) begin
          hit    = 1'b1;
          rd_val = func_sel[i];
          if (wr_go) begin
            next_func_sel[i] = gpm_upd(func_sel[i], pwdata[15:0], wr_mask, reg_op);
          end
        end
      end
      if (reg_base == gpm_pkg::OFF_BANK) begin
        hit    = 1'b1;
        rd_val = {15'h0000, bank_sel};
        if (wr_go) begin
          next_bank_sel = gpm_upd({15'h0000, bank_sel}, pwdata[15:0], wr_mask, reg_op) != 16'h0000
                          && (gpm_upd({15'h0000, bank_sel}, pwdata[15:0], wr_mask,
                                      reg_op) & 16'h0001) == 16'h0001;
        end
      end
      for (int k = 0; k < gpm_pkg::CLKO_PORTS; k++) begin
        if (reg_base == gpm_pkg::OFF_CLKO_SRC[k]) begin
          hit    = 1'b1;
          rd_val = {12'h000, clko_sel[k]};
          if (wr_go) begin
            // only the source nibble is kept; upper bits read back as zero
            next_clko_sel[k] = 4'(gpm_upd({12'h000, clko_sel[k]}, pwdata[15:0], wr_mask,
                                          reg_op));
          end
        end
      end
    end
    // read data is caught in the setup cycle so the access needs no wait state
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = {16'h0000, rd_val};
    end
  end

  // pad samples are slow signals, so two flops guard against metastability
  always_comb begin
    pin_words = {11'h000, pin_level};
    next_periph_in = '0;
    for (int p = 0; p < gpm_pkg::MUX_PINS; p++) begin
      if (pin_fn[p] != gpm_pkg::FN_NONE) begin
        next_periph_in[pin_fn[p]] = pin_level[p];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < gpm_pkg::MODE_REGS; i++) begin
        func_sel[i] <= gpm_pkg::RST_FUNC_SEL[i];
      end
      for (int k = 0; k < gpm_pkg::CLKO_PORTS; k++) begin
        clko_sel[k] <= gpm_pkg::RST_CLKO_SRC;
      end
      bank_sel  <= gpm_pkg::RST_BANK;
      pin_meta  <= '0;
      pin_level <= '0;
      prdata    <= 32'h0000_0000;
      periph_in <= '0;
    end else if (clk_en) begin
      func_sel  <= next_func_sel;
      clko_sel  <= next_clko_sel;
      bank_sel  <= next_bank_sel;
      pin_meta  <= pin_in;
      pin_level <= pin_meta;
      prdata    <= next_prdata;
      periph_in <= next_periph_in;
    end
  end

  assign pready  = clk_en;
  assign pslverr = psel && penable && !hit;

  // clock muxing is plain gating: a source change may glitch the port once
  for (genvar k = 0; k < gpm_pkg::CLKO_PORTS; k++) begin : g_clko
    assign clk_out[k] = (clko_sel[k] != 4'h0 && clko_sel[k] <= gpm_pkg::CLKO_SRC_MAX) ?
                        clk_src[clko_sel[k]] : 1'b0;
  end

  for (genvar f = 0; f < gpm_pkg::FN_COUNT; f++) begin : g_fn
    if (f >= int'(gpm_pkg::FN_CLKO) && f < int'(gpm_pkg::FN_CLKO) + 3) begin : g_ck
      assign fn_level[f] = clk_out[f - int'(gpm_pkg::FN_CLKO)];
      assign fn_en[f]    = 1'b1;
    end else begin : g_pe
      assign fn_level[f] = periph_drv.level[f];
      assign fn_en[f]    = periph_drv.en[f];
    end
  end

  for (genvar p = 0; p < gpm_pkg::MUX_PINS; p++) begin : g_pin
    assign pin_fn[p]    = gpm_route(p, func_sel[p / 8][2 * (p % 8) +: 2], bank_sel);
    assign pad_level[p] = (pin_fn[p] == gpm_pkg::FN_NONE) ? gpio_ctl.level[p] :
                          fn_level[pin_fn[p]];
    assign pad_en[p]    = (pin_fn[p] == gpm_pkg::FN_NONE) ? gpio_ctl.en[p] :
                          fn_en[pin_fn[p]];
  end

  assign pad_drv = '{level: pad_level, en: pad_en};

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_bank_reset: assert property ($fell(rst) |-> bank_sel && func_sel[2][9:8] == 2'h2
    && func_sel[4] == 16'h5555)
    else $error("bank or mode reset value wrong");
  a_pin_sample: assert property (clk_en [*3] |-> pin_level == $past(pin_in, 2))
    else $error("input register not two cycles behind pin");
  a_clko_low: assert property ((clko_sel[1] == 4'h0 || clko_sel[1] > 4'hB) |-> !clk_out[1])
    else $error("clock-out not low for empty source");
  a_clko_pick: assert property (clko_sel[0] == 4'h4 |-> clk_out[0] == clk_src[4])
    else $error("clock-out source mismatch");
  a_lcd_order: assert property (func_sel[0][15:14] == 2'h1 |->
    pad_drv.level[7] == fn_level[8])
    else $error("lcd data bit order wrong");
  a_plain_pin: assert property (func_sel[0][11:10] == 2'h0 |->
    pad_drv.level[5] == gpio_ctl.level[5] && pad_drv.en[5] == gpio_ctl.en[5])
    else $error("plain pin not under gpio control");
  a_withdrawn_pin: assert property (pad_drv.level[29] == gpio_ctl.level[29])
    else $error("withdrawn pin routed");
  a_sim_bank: assert property (func_sel[0][3:2] == 2'h3 && !bank_sel |->
    pad_drv.level[1] == gpio_ctl.level[1])
    else $error("backup sim pin routed in debug bank");
  a_debug_clk: assert property (func_sel[1][15:14] == 2'h2 |->
    pad_drv.level[15] == (bank_sel ? fn_level[23] : fn_level[24]))
    else $error("pin 15 clock choice wrong");
  a_clko_pin: assert property (func_sel[2][15:14] == 2'h3 |->
    pad_drv.level[23] == clk_out[2])
    else $error("clock-out 2 not on pin 23");
  a_reserved_aux: assert property (func_sel[3][1:0] == 2'h2 && bank_sel |->
    pad_drv.level[24] == gpio_ctl.level[24])
    else $error("reserved code routed");
  a_key_input: assert property (clk_en && func_sel[4][1:0] == 2'h1 ##1 clk_en |->
    periph_in[77] == $past(pin_level[32]))
    else $error("keypad column not sampled");
  a_bank_write: assert property (wr_go && reg_base == 12'h1C0 && reg_op == 2'h0 && pstrb[0]
    |=> bank_sel == $past(pwdata[0]))
    else $error("bank write lost");
  a_sim_aux: assert property (func_sel[0][9:8] == 2'h3 && bank_sel |->
    pad_drv.level[4] == fn_level[13])
    else $error("backup sim reset not on pin 4");
  a_int30_pin: assert property (func_sel[1][13:12] == 2'h3 |->
    pad_drv.level[14] == fn_level[21])
    else $error("interrupt 30 not on pin 14");
  a_pcm_out: assert property (func_sel[2][1:0] == 2'h1 |->
    pad_drv.level[16] == fn_level[30])
    else $error("audio pcm out not on pin 16");
  a_admux_pin: assert property (func_sel[2][9:8] == 2'h2 |->
    pad_drv.level[20] == fn_level[44])
    else $error("boot strap not on pin 20");
  a_addr_high: assert property (func_sel[3][13:12] == 2'h2 |->
    pad_drv.level[30] == fn_level[73])
    else $error("high address bit not on pin 30");
  a_swd_data: assert property (func_sel[4][3:2] == 2'h2 && !bank_sel |->
    pad_drv.level[33] == fn_level[57])
    else $error("debug data bit 3 not on pin 33");
  a_op_error: assert property (psel && penable && paddr[3:2] == 2'h3 |->
    pslverr)
    else $error("unmapped op not refused");
  a_state_freeze: assert property (!clk_en |=> bank_sel == $past(bank_sel)
    && func_sel[0] == $past(func_sel[0]))
    else $error("state moved while clock enable low");
  a_clko_top: assert property (clko_sel[5] == 4'hB |->
    clk_out[5] == clk_src[11])
    else $error("clock-out 5 source mismatch");
  a_eint_in: assert property (clk_en && func_sel[3][5:4] == 2'h2 ##1 clk_en |->
    periph_in[69] == $past(pin_level[26]))
    else $error("external interrupt 4 not sampled");

  c_debug_bank: cover property (!bank_sel ##1 bank_sel);
  c_clko_on: cover property (clko_sel[0] == 4'hB ##1 clk_out[0]);
  c_set_op: cover property (wr_go && reg_op == 2'h1 && hit);
  c_err: cover property (pslverr);
  c_freeze: cover property (!clk_en ##1 clk_en);
endmodule

/* File: test/gpm_pad_model.sv */
// pad and clock source model facing the pin mux
`timescale 1ns/1ps
module gpm_pad_model (
  input  wire logic                              mclk,
  input  wire gpm_pkg::gpm_pad_s                 pad_drv,
  input  wire logic [gpm_pkg::PIN_COUNT-1:0]     ext_lvl,
  output logic      [gpm_pkg::PIN_COUNT-1:0]     pin_in,
  output logic      [gpm_pkg::CLKO_SRC_NUM-1:0]  clk_src
);
  logic [11:0] div = 12'h000;
  // sources run free at distinct rates so a wrong select shows
  always_ff @(posedge mclk) begin
    div <= div + 12'h001;
  end
  assign clk_src = div;
  // a driven pad shows the mux level, an idle pad the outside level
  always_comb begin
    pin_in = ext_lvl;
    for (int n = 0; n < gpm_pkg::MUX_PINS; n++) begin
      if (pad_drv.en[n]) begin
        pin_in[n] = pad_drv.level[n];
      end
    end
  end
endmodule

/* File: test/tb_gpm_pin_mux.sv */
// self-checking bench for the pin function mux
`timescale 1ns/1ps
module tb_gpm_pin_mux;
  logic                             mclk, rst, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [gpm_pkg::ADDR_W-1:0]       paddr;
  logic [31:0]                      pwdata, prdata, rd;
  logic [3:0]                       pstrb;
  logic [gpm_pkg::PIN_COUNT-1:0]    pin_in, ext_lvl;
  gpm_pkg::gpm_pad_s                gpio_ctl, pad_drv;
  gpm_pkg::gpm_fn_s                 periph_drv;
  logic [gpm_pkg::FN_COUNT-1:0]     periph_in;
  logic [gpm_pkg::CLKO_SRC_NUM-1:0] clk_src;
  logic [gpm_pkg::CLKO_PORTS-1:0]   clk_out;
  logic [191:0]                     r;
  logic [3:0]                       src [6];
  logic [15:0]                      v;
  int                               error_cnt = 0, checks = 0, cyc = 0, seed, k;
  localparam logic [15:0] MRST [5] = '{16'h5555, 16'h1555, 16'h0200, 16'h5150, 16'h5555};

  gpm_pin_mux i_gpm_pin_mux (.mclk(mclk), .rst(rst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .gpio_ctl(gpio_ctl), .periph_drv(periph_drv), .pad_drv(pad_drv),
    .periph_in(periph_in), .clk_src(clk_src), .clk_out(clk_out));
  gpm_pad_model i_gpm_pad_model (.mclk(mclk), .pad_drv(pad_drv), .ext_lvl(ext_lvl),
    .pin_in(pin_in), .clk_src(clk_src));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ceiling well above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; entered just after a rising edge, leaves one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    chk(pslverr, a[3:2] == 2'h3, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [191:0] rbits();
    for (int n = 0; n < 6; n++) rbits[n*32 +: 32] = $urandom;
  endfunction
  function automatic logic clk_exp(input logic [3:0] c, input logic [11:0] s);
    return (c >= 4'h1 && c <= 4'hB) ? s[c] : 1'b0;
  endfunction
  task automatic pad_is(input int p, input logic [1:0] exp, input string what);
    chk({pad_drv.en[p], pad_drv.level[p]}, exp, what);
  endtask
  // an input function pin shows the peripheral level while that side drives it
  function automatic logic pin_exp(input int p, input int id);
    return periph_drv.en[id] ? periph_drv.level[id] : ext_lvl[p];
  endfunction
  function automatic logic [1:0] fn(input int id);
    return {periph_drv.en[id], periph_drv.level[id]};
  endfunction

  initial begin
    {rst, clk_en, pstrb} = 6'h3F;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_lvl, gpio_ctl, periph_drv} = '0;
    seed = $urandom(46295);
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, gpm_pkg::OFF_FUNC_SEL[i], 32'h0);
      chk(rd, {16'h0, MRST[i]}, "mode reset");
    end
    apb(1'b0, gpm_pkg::OFF_BANK, 32'h0);
    chk(rd[0], 1'b1, "bank reset");
    r = rbits();
    gpio_ctl <= r[79:0];
    ext_lvl <= r[132:80];
    r = rbits();
    periph_drv <= r[169:0];
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    for (int p = 0; p < 8; p++) pad_is(p, fn(1 + p), "lcd data");
    for (int p = 8; p < 15; p++) pad_is(p, fn(14 + p - 8), "lcd ctrl");
    pad_is(15, {gpio_ctl.en[15], gpio_ctl.level[15]}, "plain pin");
    for (k = 0; k < 3; k++) chk(periph_in[66 + k], pin_exp(26 + k, 66 + k), "jtag in");
    @(posedge mclk);
    apb(1'b1, gpm_pkg::OFF_FUNC_SEL[3] | 12'h008, 32'h03F0);
    apb(1'b1, gpm_pkg::OFF_FUNC_SEL[3] | 12'h004, 32'h02A0);
    apb(1'b0, gpm_pkg::OFF_FUNC_SEL[3], 32'h0);
    chk(rd, 32'h52A0, "set clear");
    repeat (3) @(posedge mclk);
    for (k = 0; k < 3; k++) chk(periph_in[69 + k], pin_exp(26 + k, 69 + k), "eint in");
    chk(periph_in[68:66], 3'h0, "jtag off");
    apb(1'b1, gpm_pkg::OFF_FUNC_SEL[0], 32'hAAFF);
    apb(1'b1, gpm_pkg::OFF_FUNC_SEL[1], 32'h9555);
    for (int b = 1; b >= 0; b--) begin
      apb(1'b1, gpm_pkg::OFF_BANK, b);
      @(negedge mclk);
      pad_is(15, fn(b ? 23 : 24), "debug clock");
      pad_is(0, fn(9), "sim data");
      pad_is(1, b ? fn(10) : {gpio_ctl.en[1], gpio_ctl.level[1]}, "sim vcc");
      for (int p = 4; p < 8; p++) pad_is(p, {gpio_ctl.en[p], gpio_ctl.level[p]}, "rsvd");
      @(posedge mclk);
    end
    gpio_ctl <= '0;
    for (int i = 0; i < 5; i++) apb(1'b1, gpm_pkg::OFF_FUNC_SEL[i], 32'h0);
    for (int t = 0; t < 6; t++) begin
      r = rbits();
      ext_lvl <= (t == 0) ? '0 : (t == 1) ? '1 : r[52:0];
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
        apb(1'b0, gpm_pkg::OFF_PIN_INPUT[i], 32'h0);
        v = (i == 3) ? {11'h0, ext_lvl[52:48]} : ext_lvl[16*i +: 16];
        chk(rd & ((i == 3) ? 32'h1F : 32'hFFFF), v, "pin input");
      end
    end
    // clock enable low freezes the sampler, so the old level must read back
    v = ext_lvl[15:0];
    clk_en <= 1'b0;
    ext_lvl <= ~ext_lvl;
    repeat (5) @(posedge mclk);
    clk_en <= 1'b1;
    apb(1'b0, gpm_pkg::OFF_PIN_INPUT[0], 32'h0);
    chk(rd, {16'h0, v}, "frozen input");
    for (int t = 0; t < 8; t++) begin
      k = $urandom % 5;
      v = $urandom;
      apb(1'b1, gpm_pkg::OFF_FUNC_SEL[k], {16'h0, v});
      apb(1'b1, gpm_pkg::OFF_FUNC_SEL[k] | 12'h00C, 32'hFFFF);
      apb(1'b0, gpm_pkg::OFF_FUNC_SEL[k], 32'h0);
      chk(rd, {16'h0, v}, "mode rw");
    end
    apb(1'b1, gpm_pkg::OFF_FUNC_SEL[2], 32'hFC00);
    apb(1'b1, gpm_pkg::OFF_BANK, 32'h1);
    for (int i = 0; i < 6; i++) src[i] = 4'h0;
    for (int c = 0; c < 16; c++) begin
      k = c % 6;
      src[k] = c[3:0];
      apb(1'b1, gpm_pkg::OFF_CLKO_SRC[k], c);
      apb(1'b0, gpm_pkg::OFF_CLKO_SRC[k], 32'h0);
      chk(rd[3:0], c[3:0], "clock source rw");
      repeat (4) begin
        @(negedge mclk);
        for (int i = 0; i < 6; i++) chk(clk_out[i], clk_exp(src[i], clk_src), "clock");
        for (int i = 0; i < 3; i++) chk(pad_drv.level[21+i], clk_exp(src[i], clk_src), "pin");
      end
      @(posedge mclk);
    end
    stop_test();
  end
endmodule
